/* File: boot_flash_model.sv */
`timescale 1ns/1ps
// --------------------
// Flash key store
// --------------------
module boot_flash_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic [19:0] key_rd_addr,
  input wire logic key_rd_req,
  output logic [31:0] key_rd_data,
  output logic key_rd_valid,
  input wire logic [19:0] key_wr_addr,
  input wire logic [31:0] key_wr_data,
  input wire logic key_wr_req,
  output logic key_wr_done
);
  logic [31:0] mem [4];
  logic [2:0] delay;
  // One answer per word; data toggles when not valid
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      delay <= 3'h0;
      key_rd_valid <= 1'b0;
      key_wr_done <= 1'b0;
      key_rd_data <= 32'h5A5A5A5A;
    end else begin
      delay <= delay + 3'h1;
      key_rd_valid <= 1'b0;
      key_wr_done <= 1'b0;
      key_rd_data <= ~key_rd_data;
      if (!slow || delay == 3'h7) begin
        if (key_rd_req && !key_rd_valid) begin
          key_rd_valid <= 1'b1;
          key_rd_data <= mem[{key_rd_addr[19], key_rd_addr[3]}];
        end
        if (key_wr_req && !key_wr_done) begin
          key_wr_done <= 1'b1;
          mem[{key_wr_addr[19], key_wr_addr[3]}] <= key_wr_data;
        end
      end
    end
  end
endmodule : boot_flash_model

/* File: boot_selector_monitor.sv */
`timescale 1ns/1ps
// --------------------
// Port checks
// --------------------
module boot_selector_monitor (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [19:0] key_rd_addr,
  input wire logic key_rd_req,
  input wire logic [19:0] key_wr_addr,
  input wire logic [31:0] key_wr_data,
  input wire logic key_wr_req,
  input wire logic swap_write,
  input wire logic [31:0] swap_wdata,
  input wire logic [19:0] cpu_addr,
  input wire logic [19:0] flash_addr,
  input wire logic map_switched,
  input wire logic core_run_enable,
  input wire logic [1:0] boot_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  run_held_a: assert property (key_rd_req |-> !core_run_enable)
    else $error("core ran during reads");
  mode_held_a: assert property (key_rd_req |-> boot_mode == 2'h0)
    else $error("mode set during reads");
  first_read_a: assert property ($rose(key_rd_req) |-> key_rd_addr == 20'h7FFC0)
    else $error("first read address");
  decide_a: assert property ($fell(key_rd_req) |-> ##[1:3] boot_mode != 2'h0)
    else $error("no decision");
  loader_hold_a: assert property (boot_mode == 2'h2 |-> !core_run_enable)
    else $error("core ran in loader");
  addr_map_a: assert property ($past(core_run_enable) && $stable(map_switched) |->
    flash_addr == ($past(cpu_addr) ^ {map_switched, 19'h0})) else $error("address map");
  swap_map_a: assert property (swap_write && swap_wdata[3] && boot_mode == 2'h1
    && !map_switched |-> ##[1:2] map_switched) else $error("swap ignored");
  first_write_a: assert property ($rose(key_wr_req) |->
    key_wr_addr == 20'h7FFC0 && key_wr_data == 32'h1) else $error("first key write");
endmodule : boot_selector_monitor

bind dual_image_boot_selector boot_selector_monitor mon_u (.core_clk, .nrst, .key_rd_addr,
  .key_rd_req, .key_wr_addr, .key_wr_data, .key_wr_req, .swap_write, .swap_wdata,
  .cpu_addr, .flash_addr, .map_switched, .core_run_enable, .boot_mode);

/* File: boot_selector_pkg.sv */
package boot_selector_pkg;
  typedef enum logic [3:0] {
    st_idle = 4'b0000,
    st_rd_rev0 = 4'b0001,
    st_rd_rev1 = 4'b0010,
    st_rd_trial0 = 4'b0011,
    st_rd_trial1 = 4'b0100,
    st_decide = 4'b0101,
    st_user = 4'b0110,
    st_download = 4'b0111,
    st_wr_rev = 4'b1000,
    st_wr_trial = 4'b1001,
    st_debug = 4'b1010
  } boot_state_t;
  typedef enum logic [1:0] {
    mode_none = 2'b00,
    mode_user = 2'b01,
    mode_loader = 2'b10,
    mode_debug = 2'b11
  } boot_mode_t;
endpackage : boot_selector_pkg

/* File: boot_selector_regs.svh */
`ifndef BOOT_SELECTOR_REGS_SVH
`define BOOT_SELECTOR_REGS_SVH

// ----------------------------------------
// Flash layout
// ----------------------------------------
`define IMAGE_SIZE 20'h80000
`define IMAGE1_BASE 20'h80000
`define IMAGE0_LAST 20'h7FFFF
`define REV_KEY_OFS 20'h7FFC0
`define TRIAL_KEY_OFS 20'h7FFC8
`define SWAP_BIT_POS 3
`define KEY_ERASED 32'hFFFFFFFF
`define KEY_PASSED 32'h00000000
`define FIRST_REV_KEY 32'h00000001
`define PIN_SETTLE_CYCLES 2'h2

`endif

/* File: dual_image_boot_selector.sv */
`timescale 1ns/1ps
`include "boot_selector_regs.svh"

module dual_image_boot_selector (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic download_select_pin,
  input wire logic aux_boot_pin,
  output logic [19:0] key_rd_addr,
  output logic key_rd_req,
  input wire logic [31:0] key_rd_data,
  input wire logic key_rd_valid,
  output logic [19:0] key_wr_addr,
  output logic [31:0] key_wr_data,
  output logic key_wr_req,
  input wire logic key_wr_done,
  input wire logic loader_done,
  input wire logic swap_write,
  input wire logic [31:0] swap_wdata,
  input wire logic [19:0] cpu_addr,
  output logic [19:0] flash_addr,
  output logic map_switched,
  output logic core_run_enable,
  output logic swd_load_enable,
  output logic [1:0] boot_mode
);
  boot_selector_pkg::boot_state_t state;
  logic dl_sel;
  logic aux_sel;
  logic [31:0] rev0;
  logic [31:0] rev1;
  logic [31:0] trial0;
  logic [31:0] trial1;
  logic img1_newer;
  logic cand_is1;
  logic cand_ok;
  logic other_ok;
  logic switched;
  logic [1:0] settle_cnt;
  logic pins_ready;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  pin_sync u_sync_dl (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin(download_select_pin),
    .pin_sync_out(dl_sel)
  );
  pin_sync u_sync_aux (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin(aux_boot_pin),
    .pin_sync_out(aux_sel)
  );

  // ----------------------------------------
  // Pin settle count
  // ----------------------------------------
  // Holds off the choice until the synchronisers carry the pins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      settle_cnt <= 2'h0;
    end else if (settle_cnt != `PIN_SETTLE_CYCLES) begin
      settle_cnt <= settle_cnt + 2'h1;
    end
  end
  assign pins_ready = (settle_cnt == `PIN_SETTLE_CYCLES);

  // ----------------------------------------
  // Key comparison
  // ----------------------------------------
  // Signed compare makes erased keys minus one
  assign img1_newer = $signed(rev1) > $signed(rev0);
  assign cand_is1 = img1_newer;
  assign cand_ok = cand_is1 ? (trial1 == `KEY_PASSED) : (trial0 == `KEY_PASSED);
  assign other_ok = cand_is1 ? (trial0 == `KEY_PASSED) : (trial1 == `KEY_PASSED);

  // ----------------------------------------
  // Selection sequencer
  // ----------------------------------------
  // Every reset re-runs selection, from the keys unless download_select_pin is set
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= boot_selector_pkg::st_idle;
      key_rd_req <= 1'b0;
      key_rd_addr <= 20'h00000;
      key_wr_req <= 1'b0;
      key_wr_addr <= 20'h00000;
      key_wr_data <= 32'h00000000;
      rev0 <= `KEY_ERASED;
      rev1 <= `KEY_ERASED;
      trial0 <= `KEY_ERASED;
      trial1 <= `KEY_ERASED;
      switched <= 1'b0;
      core_run_enable <= 1'b0;
      swd_load_enable <= 1'b0;
      boot_mode <= boot_selector_pkg::mode_none;
    end else begin
      case (state)
        boot_selector_pkg::st_idle: begin
          // Pin levels are not trusted before they settle
          if (!pins_ready) begin
            state <= boot_selector_pkg::st_idle;
          end else if (dl_sel && aux_sel) begin
            state <= boot_selector_pkg::st_debug;
          end else if (dl_sel) begin
            switched <= 1'b0;
            core_run_enable <= 1'b1;
            boot_mode <= boot_selector_pkg::mode_debug;
            state <= boot_selector_pkg::st_user;
          end else begin
            key_rd_addr <= `REV_KEY_OFS;
            key_rd_req <= 1'b1;
            state <= boot_selector_pkg::st_rd_rev0;
          end
        end
        boot_selector_pkg::st_rd_rev0: begin
          if (key_rd_valid) begin
            rev0 <= key_rd_data;
            key_rd_addr <= `IMAGE1_BASE | `REV_KEY_OFS;
            state <= boot_selector_pkg::st_rd_rev1;
          end
        end
        boot_selector_pkg::st_rd_rev1: begin
          if (key_rd_valid) begin
            rev1 <= key_rd_data;
            key_rd_addr <= `TRIAL_KEY_OFS;
            state <= boot_selector_pkg::st_rd_trial0;
          end
        end
        boot_selector_pkg::st_rd_trial0: begin
          if (key_rd_valid) begin
            trial0 <= key_rd_data;
            key_rd_addr <= `IMAGE1_BASE | `TRIAL_KEY_OFS;
            state <= boot_selector_pkg::st_rd_trial1;
          end
        end
        boot_selector_pkg::st_rd_trial1: begin
          if (key_rd_valid) begin
            trial1 <= key_rd_data;
            key_rd_req <= 1'b0;
            state <= boot_selector_pkg::st_decide;
          end
        end
        boot_selector_pkg::st_decide: begin
          // Core released in the same cycle as switched is set; map_switched follows one cycle later
          if (cand_ok) begin
            switched <= cand_is1;
            core_run_enable <= 1'b1;
            boot_mode <= boot_selector_pkg::mode_user;
            state <= boot_selector_pkg::st_user;
          end else if (other_ok) begin
            switched <= ~cand_is1;
            core_run_enable <= 1'b1;
            boot_mode <= boot_selector_pkg::mode_user;
            state <= boot_selector_pkg::st_user;
          end else begin
            switched <= 1'b0;
            boot_mode <= boot_selector_pkg::mode_loader;
            state <= boot_selector_pkg::st_download;
          end
        end
        boot_selector_pkg::st_user: begin
          // Firmware swap during trial run
          if (swap_write && swap_wdata[`SWAP_BIT_POS]) begin
            switched <= ~switched;
          end
        end
        boot_selector_pkg::st_download: begin
          if (loader_done) begin
            key_wr_addr <= `REV_KEY_OFS;
            key_wr_data <= `FIRST_REV_KEY;
            key_wr_req <= 1'b1;
            state <= boot_selector_pkg::st_wr_rev;
          end
        end
        boot_selector_pkg::st_wr_rev: begin
          if (key_wr_done) begin
            key_wr_addr <= `TRIAL_KEY_OFS;
            key_wr_data <= `KEY_PASSED;
            state <= boot_selector_pkg::st_wr_trial;
          end
        end
        boot_selector_pkg::st_wr_trial: begin
          if (key_wr_done) begin
            key_wr_req <= 1'b0;
          end
        end
        boot_selector_pkg::st_debug: begin
          swd_load_enable <= 1'b1;
          boot_mode <= boot_selector_pkg::mode_debug;
        end
        default: begin
          state <= boot_selector_pkg::st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Address mapping
  // ----------------------------------------
  // Switched mapping flips the top address bit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flash_addr <= 20'h00000;
      map_switched <= 1'b0;
    end else begin
      flash_addr <= {cpu_addr[19] ^ switched, cpu_addr[18:0]};
      map_switched <= switched;
    end
  end
endmodule : dual_image_boot_selector

/* File: pin_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for a pin level
module pin_sync (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic pin,
  output logic pin_sync_out
);
  logic stage1;

  // ----------------------------------------
  // Synchroniser flops
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= 1'b0;
      pin_sync_out <= 1'b0;
    end else begin
      stage1 <= pin;
      pin_sync_out <= stage1;
    end
  end
endmodule : pin_sync

/* File: tb_top.sv */
`timescale 1ns/1ps
// --------------------
// Boot selector bench
// --------------------
module tb_top;
  localparam logic [31:0] erased = 32'hFFFFFFFF;
  logic core_clk = 1'b0, nrst = 1'b0, download_select_pin = 1'b0, aux_boot_pin = 1'b0;
  logic loader_done = 1'b0, swap_write = 1'b0, slow = 1'b0;
  logic [31:0] swap_wdata = 32'h0, key_rd_data, key_wr_data;
  logic [19:0] cpu_addr = 20'h0, key_rd_addr, key_wr_addr, flash_addr;
  logic key_rd_req, key_rd_valid, key_wr_req, key_wr_done, map_switched;
  logic core_run_enable, swd_load_enable;
  logic [1:0] boot_mode;
  int err_count = 0, comparisons = 0, cycles = 0;
  always #12.5 core_clk = ~core_clk;
  dual_image_boot_selector dut_u (.core_clk, .nrst, .download_select_pin, .aux_boot_pin,
    .key_rd_addr, .key_rd_req, .key_rd_data, .key_rd_valid, .key_wr_addr, .key_wr_data,
    .key_wr_req, .key_wr_done, .loader_done, .swap_write, .swap_wdata, .cpu_addr,
    .flash_addr, .map_switched, .core_run_enable, .swd_load_enable, .boot_mode);
  boot_flash_model flash_u (.core_clk, .nrst, .slow, .key_rd_addr, .key_rd_req, .key_rd_data,
    .key_rd_valid, .key_wr_addr, .key_wr_data, .key_wr_req, .key_wr_done);
  // Cut a hang short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : tick
  // Load keys, reset, wait for the decision
  task automatic boot(input logic [31:0] r0, t0, r1, t1);
    flash_u.mem = '{r0, t0, r1, t1};
    tick(1);
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    for (int i = 0; i < 80 && boot_mode === 2'h0; i++) tick(1);
    cpu_addr = 20'h00123;
    tick(3);
  endtask : boot
  task automatic expect_run(input logic [1:0] mode, input logic sw);
    check(32'(boot_mode), 32'(mode));
    check(32'(map_switched), 32'(sw));
    check(32'(core_run_enable), 32'(mode != 2'h2));
    if (mode != 2'h2) check(32'(flash_addr), 32'({sw, 19'h00123}));
  endtask : expect_run
  task automatic pulse_swap;
    swap_wdata = 32'h8;
    swap_write = 1'b1;
    tick(1);
    swap_write = 1'b0;
    cpu_addr = 20'h00123;
    tick(3);
  endtask : pulse_swap
  // Firmware side: swap only when the active revision is the older one
  task automatic fw_start;
    logic [31:0] act;
    logic [31:0] oth;
    act = map_switched ? flash_u.mem[2] : flash_u.mem[0];
    oth = map_switched ? flash_u.mem[0] : flash_u.mem[2];
    if ($signed(act) < $signed(oth)) pulse_swap();
    else tick(4);
  endtask : fw_start
  task automatic t_select;
    boot(erased, erased, erased, erased);
    expect_run(2'h2, 1'b0);
    boot(32'h1, 32'h0, erased, erased);
    expect_run(2'h1, 1'b0);
    boot(erased, erased, 32'h1, 32'h0);
    expect_run(2'h1, 1'b1);
    slow = 1'b1;
    boot(32'h1, 32'h0, 32'h2, 32'h0);
    expect_run(2'h1, 1'b1);
    boot(32'h3, erased, 32'h2, 32'h0);
    expect_run(2'h1, 1'b1);
    boot(32'h3, erased, 32'h2, erased);
    expect_run(2'h2, 1'b0);
    slow = 1'b0;
    $display("t_select finished");
  endtask : t_select
  task automatic t_loader;
    boot(erased, erased, erased, erased);
    pulse_swap();
    check(32'(map_switched), 32'h0);
    loader_done = 1'b1;
    tick(1);
    loader_done = 1'b0;
    for (int i = 0; i < 40 && key_wr_req !== 1'b0; i++) tick(1);
    check(flash_u.mem[0], 32'h1);
    check(flash_u.mem[1], 32'h0);
    boot(flash_u.mem[0], flash_u.mem[1], flash_u.mem[2], flash_u.mem[3]);
    expect_run(2'h1, 1'b0);
    $display("t_loader finished");
  endtask : t_loader
  task automatic t_swap;
    boot(32'h1, 32'h0, 32'h2, erased);
    expect_run(2'h1, 1'b0);
    fw_start();
    expect_run(2'h1, 1'b1);
    boot(32'h1, 32'h0, 32'h2, erased);
    expect_run(2'h1, 1'b0);
    boot(32'h1, 32'h0, 32'h2, 32'h0);
    expect_run(2'h1, 1'b1);
    fw_start();
    expect_run(2'h1, 1'b1);
    $display("t_swap finished");
  endtask : t_swap
  task automatic t_pins;
    download_select_pin = 1'b1;
    boot(erased, erased, erased, erased);
    expect_run(2'h3, 1'b0);
    aux_boot_pin = 1'b1;
    boot(erased, erased, erased, erased);
    check(32'(swd_load_enable), 32'h1);
    check(32'(boot_mode), 32'h3);
    download_select_pin = 1'b0;
    aux_boot_pin = 1'b0;
    $display("t_pins finished");
  endtask : t_pins
  initial begin
    t_select();
    t_loader();
    t_swap();
    t_pins();
    report_and_stop();
  end
endmodule : tb_top
